/* verilog/dcrc_engine.sv */
// DMA checksum engine: control registers, byte reorder, LFSR CRC or IP checksum.
// Assumes a classic Wishbone master and a DMA data path on the same clock.
`timescale 1ns/1ns
`include "dcrc_consts.svh"

// Contract
// (RQ1) Source bytes are reordered by the two-bit byte order field: keep, reverse word, swap halves, swap in halves.
// (RQ2) With write reorder set the destination gets reordered data, otherwise data unchanged.
// (RQ3) While write reorder is 1 unaligned beats are not served and append mode cannot be set.
// (RQ4) In IP checksum mode the bit reflect bit selects LSB-first or MSB-first calculation.
// (RQ5) In LFSR mode the bit reflect bit selects a reflected or unreflected CRC.
// (RQ6) The polynomial length field is length minus one in LFSR mode and is ignored in IP mode.
// (RQ7) With the enable bit set the selected channel passes through the unit, else it passes untouched.
// (RQ8) Append mode feeds data only to the checksum and writes the result to the destination start at block end.
// (RQ9) Without append mode data goes to the checksum and to the destination, obeying write reorder.
// (RQ10) Type select 1 chooses IP header checksum and 0 chooses LFSR CRC.
// (RQ11) The unit attaches to the channel whose number equals the three-bit channel select field.
// (RQ12) Software loads the source start register with a physical address.
// (RQ13) Software loads the destination start register with a physical address.
// (RQ14) Unimplemented control bits read as zero and ignore writes.
// (RQ15) All control fields and both start addresses reset to zero.
// (RQ16) IP checksum mode accumulates a 16-bit ones' complement sum.
module dcrc_engine
  import dcrc_pkg::*;
#(
  parameter int NUM_CHAN = `DCRC_NUM_CHAN
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [2:0] src_chan_i,
  input wire logic [31:0] src_data_i,
  input wire logic [31:0] src_addr_i,
  input wire logic src_last_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  output logic [31:0] dst_data_o,
  output logic [31:0] dst_addr_o,
  output logic dst_last_o,
  output logic dst_valid_o,
  input wire logic dst_ready_i,
  output logic [31:0] checksum_o,
  output logic busy_o
);
  initial
  begin
    if (NUM_CHAN != 8)
    begin
      $error("dcrc_engine: channel select is three bits, NUM_CHAN must be 8");
    end
  end

  logic [31:0] ctrl_q;
  logic [31:0] src_start_q;
  logic [31:0] dst_start_q;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic ack_q;
  logic in_block_q;
  logic append_pend_q;
  logic [31:0] wr_data;
  logic [31:0] ctrl_wr;
  logic [31:0] poly_q;

  // Field views
  wire dcrc_byte_order_t byte_order_sel = dcrc_byte_order_t'(ctrl_q[`DCRC_F_BORD_HI:`DCRC_F_BORD_LO]);
  wire write_reorder = ctrl_q[`DCRC_F_WRREORD];
  wire bit_reflect = ctrl_q[`DCRC_F_BITREF];
  wire [4:0] poly_length_m1 = ctrl_q[`DCRC_F_PLM1_HI:`DCRC_F_PLM1_LO];
  wire checksum_enable = ctrl_q[`DCRC_F_ENABLE];
  wire append_mode = ctrl_q[`DCRC_F_APPEND];
  wire checksum_type = ctrl_q[`DCRC_F_TYPE];
  wire [2:0] channel_select = ctrl_q[`DCRC_F_CHAN_HI:`DCRC_F_CHAN_LO];

  // Bus decode
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire sel_ctrl = (wb_adr_i == `DCRC_OFS_CONTROL);
  wire sel_src = (wb_adr_i == `DCRC_OFS_SRC_START);
  wire sel_dst = (wb_adr_i == `DCRC_OFS_DST_START);
  wire sel_res = (wb_adr_i == `DCRC_OFS_RESULT);
  wire mapped = sel_ctrl || sel_src || sel_dst || sel_res;
  wire wr_ok = wb_req && wb_we_i && mapped;
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Byte reorder of the incoming word
  logic [31:0] reordered;
  always_comb
  begin
    unique case (byte_order_sel) // RQ1
      DCRC_BO_KEEP: reordered = src_data_i;
      DCRC_BO_WORD_REV: reordered = {src_data_i[7:0], src_data_i[15:8], src_data_i[23:16], src_data_i[31:24]};
      DCRC_BO_HALF_SWAP: reordered = {src_data_i[15:0], src_data_i[31:16]};
      DCRC_BO_HALF_BYTE_SWAP: reordered = {src_data_i[23:16], src_data_i[31:24], src_data_i[7:0], src_data_i[15:8]};
    endcase
  end

  // Routing of the data path
  wire chan_hit = checksum_enable && (src_chan_i == channel_select); // RQ7 RQ11
  wire unaligned = (src_addr_i[1:0] != 2'b00);
  wire refuse_beat = chan_hit && write_reorder && unaligned; // RQ3
  wire take_beat = src_valid_i && src_ready_o;
  wire crc_beat = take_beat && chan_hit;
  wire forward = !(chan_hit && append_mode); // RQ8 RQ9
  wire [31:0] fwd_data = (chan_hit && write_reorder) ? reordered : src_data_i; // RQ2
  wire [31:0] crc_feed = reordered;
  wire buf_in_ready;
  wire buf_in_valid = append_pend_q ? 1'b1 : (src_valid_i && forward && !refuse_beat);
  wire dcrc_beat_t buf_in = append_pend_q ? dcrc_beat_t'{data: crc_q, addr: dst_start_q, last: 1'b1}
                                          : dcrc_beat_t'{data: fwd_data, addr: src_addr_i, last: src_last_i};
  wire dcrc_beat_t buf_out;
  wire append_taken = append_pend_q && buf_in_ready;

  assign src_ready_o = !append_pend_q && !refuse_beat && (!forward || buf_in_ready);
  assign checksum_o = crc_q;
  assign busy_o = in_block_q || append_pend_q;
  assign wb_ack_o = ack_q;
  assign wb_err_o = 1'b0;
  assign dst_data_o = buf_out.data;
  assign dst_addr_o = buf_out.addr;
  assign dst_last_o = buf_out.last;

  dcrc_skid #(.WIDTH($bits(dcrc_beat_t))) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(buf_in),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_out),
    .out_valid_o(dst_valid_o),
    .out_ready_i(dst_ready_i)
  );

  // Checksum step for one word
  wire [31:0] poly_mask = (poly_length_m1 == 5'd31) ? 32'hFFFF_FFFF : ((32'h0000_0002 << poly_length_m1) - 32'h0000_0001);
  wire [31:0] top_bit = 32'h0000_0001 << poly_length_m1;
  wire [31:0] feed_bits = bit_reflect ? {<<{crc_feed}} : crc_feed; // RQ4 RQ5
  logic [31:0] lfsr;
  logic [16:0] sum_a;
  logic [16:0] sum_b;
  logic [15:0] sum_c;
  always_comb
  begin
    lfsr = crc_q;
    for (int i = 31; i >= 0; i--)
    begin
      if (((lfsr & top_bit) != 32'h0000_0000) ^ feed_bits[i])
      begin
        lfsr = ((lfsr << 1) ^ poly_q) & poly_mask; // RQ6
      end
      else
      begin
        lfsr = (lfsr << 1) & poly_mask;
      end
    end
    sum_a = {1'b0, crc_q[15:0]} + {1'b0, feed_bits[31:16]}; // RQ16
    sum_b = {1'b0, sum_a[15:0]} + {16'h0000, sum_a[16]} + {1'b0, feed_bits[15:0]};
    sum_c = sum_b[15:0] + {15'h0000, sum_b[16]};
    crc_d = checksum_type ? {16'h0000, sum_c} : lfsr; // RQ10
  end

  // Write data with byte enables; append refused while write reorder is set
  assign wr_data = wb_dat_i & byte_mask;
  always_comb
  begin
    ctrl_wr = ((ctrl_q & ~byte_mask) | wr_data) & `DCRC_CTRL_MASK; // RQ14
    if (ctrl_wr[`DCRC_F_WRREORD])
    begin
      ctrl_wr[`DCRC_F_APPEND] = 1'b0; // RQ3
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `DCRC_RESET_WORD; // RQ15
      src_start_q <= `DCRC_RESET_WORD;
      dst_start_q <= `DCRC_RESET_WORD;
      poly_q <= `DCRC_RESET_WORD;
    end
    else if (wr_ok)
    begin
      if (sel_ctrl) ctrl_q <= ctrl_wr;
      if (sel_src) src_start_q <= (src_start_q & ~byte_mask) | wr_data; // RQ12
      if (sel_dst) dst_start_q <= (dst_start_q & ~byte_mask) | wr_data; // RQ13
      if (sel_res) poly_q <= (poly_q & ~byte_mask) | wr_data;
    end
  end

  // Checksum state, block tracking and append write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crc_q <= `DCRC_RESET_WORD;
      in_block_q <= 1'b0;
      append_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_ok && sel_ctrl)
      begin
        crc_q <= `DCRC_RESET_WORD;
      end
      else if (crc_beat)
      begin
        crc_q <= crc_d;
      end
      if (crc_beat)
      begin
        in_block_q <= !src_last_i;
      end
      if (crc_beat && src_last_i && append_mode)
      begin
        append_pend_q <= 1'b1; // RQ8
      end
      else if (append_taken)
      begin
        append_pend_q <= 1'b0;
      end
    end
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        wb_dat_o <= sel_ctrl ? ctrl_q : sel_src ? src_start_q : sel_dst ? dst_start_q : sel_res ? crc_q : 32'h0000_0000;
      end
    end
  end

  AST_CTRL_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q & ~`DCRC_CTRL_MASK) == 32'h0000_0000) else $error("reserved control bits set"); // RQ14
  AST_NO_APPEND_WITH_REORDER: assert property (@(posedge clk_i) disable iff (rst_i)
    !(write_reorder && append_mode)) else $error("append set with write reorder"); // RQ3
  AST_UNALIGNED_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
    refuse_beat |-> !src_ready_o) else $error("unaligned beat accepted"); // RQ3
  AST_APPEND_NOT_FORWARDED: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid_i && chan_hit && append_mode && !append_pend_q) |-> !buf_in_valid) else $error("append data forwarded"); // RQ8
  AST_APPEND_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
    (crc_beat && src_last_i && append_mode) |=> append_pend_q ##0 (buf_in.addr == dst_start_q)) else $error("append missing"); // RQ8
  AST_PASS_UNCHANGED: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid_i && !chan_hit && !append_pend_q) |-> (buf_in.data == src_data_i)) else $error("data altered off channel"); // RQ7
  AST_REORDER_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid_i && chan_hit && write_reorder && !append_pend_q) |-> (buf_in.data == reordered)) else $error("reorder not applied"); // RQ2
  AST_CRC_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (crc_beat && !(wr_ok && sel_ctrl)) |=> (crc_q == $past(crc_d))) else $error("checksum not updated"); // RQ10
  AST_IP_SUM_16: assert property (@(posedge clk_i) disable iff (rst_i)
    (crc_beat && checksum_type && !(wr_ok && sel_ctrl)) |=> (crc_q[31:16] == 16'h0000)) else $error("ip sum wide"); // RQ16
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q) else $error("ack timing"); // ack high for the one cycle after a request, then low
endmodule

/* common/dcrc_consts.svh */
// Constants for the DMA checksum engine: offsets, fields, reset values.
// Included by the package users; holds definitions only.
`ifndef DCRC_CONSTS_SVH
`define DCRC_CONSTS_SVH
`define DCRC_OFS_CONTROL 4'h0
`define DCRC_OFS_SRC_START 4'h4
`define DCRC_OFS_DST_START 4'h8
`define DCRC_OFS_RESULT 4'hC
`define DCRC_CTRL_MASK 32'h3900_1FE7
`define DCRC_RESET_WORD 32'h0000_0000
`define DCRC_F_BORD_HI 29
`define DCRC_F_BORD_LO 28
`define DCRC_F_WRREORD 27
`define DCRC_F_BITREF 24
`define DCRC_F_PLM1_HI 12
`define DCRC_F_PLM1_LO 8
`define DCRC_F_ENABLE 7
`define DCRC_F_APPEND 6
`define DCRC_F_TYPE 5
`define DCRC_F_CHAN_HI 2
`define DCRC_F_CHAN_LO 0
`define DCRC_NUM_CHAN 8
`endif

/* common/dcrc_pkg.sv */
// Types shared by the DMA checksum engine and its two-entry buffer.
// Assumes the constants header is on the include path.
package dcrc_pkg;
  typedef enum logic [1:0] {
    DCRC_BO_KEEP,
    DCRC_BO_WORD_REV,
    DCRC_BO_HALF_SWAP,
    DCRC_BO_HALF_BYTE_SWAP
  } dcrc_byte_order_t;

  typedef struct packed {
    logic [31:0] data;
    logic [31:0] addr;
    logic last;
  } dcrc_beat_t;

  typedef struct packed {
    dcrc_byte_order_t byte_order_sel;
    logic write_reorder;
    logic bit_reflect;
    logic [4:0] poly_length_m1;
    logic checksum_enable;
    logic append_mode;
    logic checksum_type;
    logic [2:0] channel_select;
  } dcrc_ctrl_t;
endpackage

/* verilog/dcrc_skid.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module dcrc_skid
  import dcrc_pkg::*;
#(
  parameter int WIDTH = 65
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  initial
  begin
    if (WIDTH < 1)
    begin
      $error("dcrc_skid: WIDTH must be positive");
    end
  end

  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count_q != 2'd2);
  assign out_valid_o = (count_q != 2'd0);
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* testbench/dcrc_dma_model.sv */
// DMA channel model: feeds source beats, collects destination beats.
// Assumes the engine's clock; beats change just after a rising edge.
`timescale 1ns/1ns
module dcrc_dma_model
  import dcrc_pkg::*;
(
  input wire logic clk_i,
  output logic [2:0] src_chan_o,
  output logic [31:0] src_data_o,
  output logic [31:0] src_addr_o,
  output logic src_last_o,
  output logic src_valid_o,
  input wire logic src_ready_i,
  input wire logic [31:0] dst_data_i,
  input wire logic [31:0] dst_addr_i,
  input wire logic dst_last_i,
  input wire logic dst_valid_i,
  output logic dst_ready_o
);
  logic stall = 1'b0;
  logic rdy_pre = 1'b0;
  dcrc_beat_t rx_q[$];
  initial
  begin
    {src_chan_o, src_data_o, src_addr_o, src_last_o, src_valid_o} = '0;
    dst_ready_o = 1'b1;
  end
  // Ready settles well before the next edge
  always @(negedge clk_i)
    rdy_pre = src_ready_i;
  always @(posedge clk_i)
  begin
    if (dst_valid_i && dst_ready_o)
      rx_q.push_back({dst_data_i, dst_addr_i, dst_last_i});
    dst_ready_o <= !stall;
  end
  // Holds a beat until taken, then shows a changed pattern
  task automatic send(input logic [2:0] ch, input logic [31:0] d, input logic [31:0] a, input logic l);
    {src_chan_o, src_data_o, src_addr_o, src_last_o, src_valid_o} <= {ch, d, a, l, 1'b1};
    do
      @(posedge clk_i);
    while (!rdy_pre);
    {src_data_o, src_addr_o, src_valid_o} <= {~d, ~a, 1'b0};
    @(posedge clk_i);
  endtask
endmodule

/* testbench/tb_dcrc_engine.sv */
// Bench for the DMA checksum engine: registers, reorder, append, stall.
// Assumes the package, the constants header and the DMA channel model.
`timescale 1ns/1ns
module tb_dcrc_engine
  import dcrc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, dat_pre, checksum_o, src_data_i, src_addr_i, dst_data_o, dst_addr_o;
  logic wb_ack_o, ack_pre, wb_err_o, busy_o, src_last_i, src_valid_i, src_ready_o;
  logic dst_last_o, dst_valid_o, dst_ready_i;
  logic [2:0] src_chan_i;
  int fail_count = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int i;
  dcrc_beat_t b;
  logic [67:0] reg_rows [6] = '{{4'h2, 32'hFFFF_FFFF, 32'h0000_0000}, {4'h0, 32'hFFFF_FFFF, 32'h3900_1FA7},
    {4'h0, 32'h0800_0040, 32'h0800_0000}, {4'h0, 32'h0000_00E5, 32'h0000_00E5},
    {4'h4, 32'h1234_5678, 32'h1234_5678}, {4'h8, 32'hA5A5_0F0F, 32'hA5A5_0F0F}};
  logic [66:0] str_rows [8] = '{{32'h0800_0082, 3'h2, 32'h1122_3344}, {32'h1800_0082, 3'h2, 32'h4433_2211},
    {32'h2800_0082, 3'h2, 32'h3344_1122}, {32'h3800_0082, 3'h2, 32'h2211_4433},
    {32'h1000_0082, 3'h2, 32'h1122_3344}, {32'h1800_0082, 3'h3, 32'h1122_3344},
    {32'h1800_0002, 3'h2, 32'h1122_3344}, {32'h1800_0087, 3'h7, 32'h4433_2211}};
  dcrc_engine i_dcrc_engine (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .src_chan_i, .src_data_i, .src_addr_i, .src_last_i,
    .src_valid_i, .src_ready_o, .dst_data_o, .dst_addr_o, .dst_last_o, .dst_valid_o, .dst_ready_i,
    .checksum_o, .busy_o);
  dcrc_dma_model i_dcrc_dma_model (.clk_i, .src_chan_o(src_chan_i), .src_data_o(src_data_i),
    .src_addr_o(src_addr_i), .src_last_o(src_last_i), .src_valid_o(src_valid_i), .src_ready_i(src_ready_o),
    .dst_data_i(dst_data_o), .dst_addr_i(dst_addr_o), .dst_last_i(dst_last_o), .dst_valid_i(dst_valid_o),
    .dst_ready_o(dst_ready_i));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
  begin
    ack_pre = wb_ack_o;
    dat_pre = wb_dat_o;
  end
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
    do
      @(posedge clk_i);
    while (!ack_pre);
    q = dat_pre;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic get(output dcrc_beat_t bt);
    int n;
    n = 0;
    while (i_dcrc_dma_model.rx_q.size() == 0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    bt = (n < 40) ? i_dcrc_dma_model.rx_q.pop_front() : 'x;
  endtask
  task automatic rst_chk();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 4; k++)
      rd("reset value", 4'(k * 4), 32'h0000_0000);
  endtask
  initial
  begin
    rst_chk();
    foreach (reg_rows[r])
    begin
      wr(reg_rows[r][67:64], reg_rows[r][63:32]);
      rd("register", reg_rows[r][67:64], reg_rows[r][31:0]);
    end
    foreach (str_rows[r])
    begin
      wr(4'h0, str_rows[r][66:35]);
      i_dcrc_dma_model.send(str_rows[r][34:32], 32'h1122_3344, 32'h0000_0100, 1'b1);
      get(b);
      chk("dest data", str_rows[r][31:0], b.data);
    end
    wr(4'h8, 32'h0000_2000);
    wr(4'h0, 32'h0000_1FE1);
    i_dcrc_dma_model.send(3'h1, 32'h0001_0002, 32'h0000_0200, 1'b0);
    i_dcrc_dma_model.send(3'h1, 32'h0003_0004, 32'h0000_0204, 1'b1);
    get(b);
    chk("append data", 32'h0000_000A, b.data);
    chk("append addr", 32'h0000_2000, b.addr);
    chk("append last", 32'h0000_0001, 32'(b.last));
    repeat (4) @(posedge clk_i);
    chk("dest count", 32'h0000_0000, 32'(i_dcrc_dma_model.rx_q.size()));
    rd("sum", 4'hC, 32'h0000_000A);
    chk("checksum out", 32'h0000_000A, checksum_o);
    chk("bus error", 32'h0000_0000, 32'(wb_err_o));
    wr(4'hC, 32'h0000_0007);
    for (i = 0; i < 2; i++)
    begin
      wr(4'h0, i ? 32'h0100_0781 : 32'h0000_0781);
      i_dcrc_dma_model.send(3'h1, i ? 32'h8000_0000 : 32'h0000_0001, 32'h0000_0500, 1'b1);
      get(b);
      rd("lfsr", 4'hC, 32'h0000_0007);
    end
    for (i = 0; i < 2; i++)
    begin
      wr(4'h0, i ? 32'h0000_00A1 : 32'h0100_00A1);
      i_dcrc_dma_model.send(3'h1, 32'h0000_8000, 32'h0000_0300, 1'b1);
      get(b);
      rd("ip sum", 4'hC, i ? 32'h0000_8000 : 32'h0000_0001);
    end
    wr(4'h0, 32'h0000_0080);
    i_dcrc_dma_model.stall = 1'b1;
    fork
      for (int k = 0; k < 6; k++)
        i_dcrc_dma_model.send(3'h0, 32'h0000_0010 + k, 32'h0000_0400, 1'b0);
    join_none
    repeat (20) @(posedge clk_i);
    chk("ready when full", 32'h0000_0000, 32'(i_dcrc_dma_model.rdy_pre));
    i_dcrc_dma_model.stall = 1'b0;
    for (i = 0; i < 6; i++)
    begin
      get(b);
      chk("drained data", 32'h0000_0010 + i, b.data);
      chk("drained addr", 32'h0000_0400, b.addr);
    end
    chk("busy", 32'h0000_0001, 32'(busy_o));
    wr(4'h0, 32'h0800_0082);
    fork
      i_dcrc_dma_model.send(3'h2, 32'h1122_3344, 32'h0000_0101, 1'b1);
    join_none
    repeat (10) @(posedge clk_i);
    chk("unaligned ready", 32'h0000_0000, 32'(i_dcrc_dma_model.rdy_pre));
    rst_chk();
    test_done();
  end
endmodule
